// ### core/scslp_pkg.sv
// constants and carrier types for the system control, low power and priority block
// assumes a single hclk domain and an AHB-Lite register port
// Notes on behaviour
// - pending-event select 0: only enabled interrupts wake
// - pending-event select 1: any interrupt wakes
// - event wakes waiter, else latched for next
// - send-event instruction also makes a wake event
// - deep sleep select picks sleep or deep
// - sleep on handler return only when enabled
// - indicator register ignores all writes
// - stack alignment indicator always reads one
// - status bit nine records and restores alignment
// - unaligned indicator one; unaligned access faults
// - each system handler priority is 0..3
// - eight-bit fields keep bits 7:6 only
// - supervisor call priority in bits 31:24
// - tick timer priority in bits 31:24
// - pendable service priority in bits 23:16
package scslp_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_LPC        = 8'h00;
  localparam logic [7:0]  OFS_CBI        = 8'h04;
  localparam logic [7:0]  OFS_HP2        = 8'h08;
  localparam logic [7:0]  OFS_HP3        = 8'h0c;
  // field positions
  localparam int          LPC_EVPEND_BIT = 4;
  localparam int          LPC_DEEP_BIT   = 2;
  localparam int          LPC_SOE_BIT    = 1;
  localparam int          CBI_STK_BIT    = 9;
  localparam int          CBI_UNAL_BIT   = 3;
  localparam int          PRI_SVC_LSB    = 24;
  localparam int          PRI_TICK_LSB   = 24;
  localparam int          PRI_PEND_LSB   = 16;
  localparam int          PRI_KEEP_OFS   = 6;
  localparam int          PSR_ALIGN_BIT  = 9;
  // fixed and reset values
  localparam logic [31:0] CBI_VALUE      = 32'h0000_0208;
  localparam logic [1:0]  PRI_RESET      = 2'h0;
  localparam logic        LPC_BIT_RESET  = 1'b0;
  // bus encodings
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic [1:0]  ASIZE_HALF     = 2'h1;
  localparam logic [1:0]  ASIZE_WORD     = 2'h2;

  typedef enum logic {WK_RUN, WK_WAIT} scslp_wk_t;

  typedef struct packed {
    logic [1:0] svc;
    logic [1:0] pend;
    logic [1:0] tick;
  } scslp_prio_t;

  typedef struct packed {
    logic irq_new;
    logic irq_new_enabled;
    logic event_in;
    logic sev_exec;
    logic wfe_exec;
  } scslp_wake_in_t;

  typedef struct packed {
    logic wake_up;
    logic sleep_request;
    logic deep_sleep;
    logic event_latched;
  } scslp_pwr_out_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        evpend_sel;
    logic        deep_sel;
    logic        soe_sel;
    scslp_prio_t prio;
    scslp_wk_t   wk;
    logic        event_latched;
    logic        wake_up;
    logic        sleep_req;
  } scslp_state_t;
endpackage

// ### core/scslp_align.sv
// stack alignment on exception entry/return and unaligned access trap
// purely combinational; the caller samples the results
module scslp_align (
  input  logic        exc_entry,
  input  logic        exc_return,
  input  logic [31:0] sp_in,
  input  logic        psr_align_in,
  input  logic        access_valid,
  input  logic [1:0]  access_addr,
  input  logic [1:0]  access_size,
  output logic [31:0] sp_out,
  output logic        psr_align_out,
  output logic        hard_fault_req
);
  // entry rounds down to 8 bytes and records the pad, return adds it back
  always_comb begin
    sp_out        = sp_in;
    psr_align_out = 1'b0;
    if (exc_entry) begin
      sp_out        = {sp_in[31:3], 3'h0};
      psr_align_out = sp_in[2];
    end else if (exc_return && psr_align_in) begin
      sp_out = sp_in | 32'h0000_0004;
    end
  end

  // every misaligned half or word access traps, no fixup path exists
  always_comb begin
    hard_fault_req = 1'b0;
    if (access_valid) begin
      if (access_size == scslp_pkg::ASIZE_HALF) hard_fault_req = access_addr[0];
      else if (access_size == scslp_pkg::ASIZE_WORD) hard_fault_req = |access_addr;
    end
  end
endmodule

// ### core/scslp_arb.sv
// picks the most urgent pending configurable system exception
// index 0 supervisor call, 1 pendable service, 2 tick timer
module scslp_arb (
  input  logic [2:0]            pend,
  input  scslp_pkg::scslp_prio_t prio,
  output logic                  win_valid,
  output logic [1:0]            win_id
);
  logic [1:0] lvl [3];
  logic [1:0] best;

  assign lvl[0] = prio.svc;
  assign lvl[1] = prio.pend;
  assign lvl[2] = prio.tick;

  // strict less-than so ties go to the lower exception number
  always_comb begin
    win_valid = 1'b0;
    win_id    = 2'h0;
    best      = 2'h3;
    for (int i = 0; i < 3; i++) begin
      if (pend[i] && (!win_valid || lvl[i] < best)) begin
        win_valid = 1'b1;
        win_id    = 2'(i);
        best      = lvl[i];
      end
    end
  end
endmodule

// ### core/scslp_top.sv
// system control registers: low power control, behaviour indicators,
// handler priorities, wake/event logic and sleep-on-exit request
// assumes one AHB-Lite master, word transfers, inputs synchronous to hclk
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
module scslp_top (
  input  logic                     hclk,
  input  logic                     hresetn,
  input  logic                     hce,
  input  logic                     hsel,
  input  logic [31:0]              haddr,
  input  logic [1:0]               htrans,
  input  logic                     hwrite,
  input  logic [2:0]               hsize,
  input  logic [31:0]              hwdata,
  input  logic                     hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  scslp_pkg::scslp_wake_in_t wake_in,
  input  logic                     handler_return_to_thread,
  output scslp_pkg::scslp_pwr_out_t pwr_out,
  input  logic [2:0]               sys_pend,
  output logic                     sys_win_valid,
  output logic [1:0]               sys_win_id,
  output scslp_pkg::scslp_prio_t   sys_prio,
  input  logic                     exc_entry,
  input  logic                     exc_return,
  input  logic [31:0]              sp_in,
  input  logic                     psr_align_in,
  output logic [31:0]              sp_out,
  output logic                     psr_align_out,
  input  logic                     access_valid,
  input  logic [1:0]               access_addr,
  input  logic [1:0]               access_size,
  output logic                     hard_fault_req
);
  scslp_pkg::scslp_state_t s;
  scslp_pkg::scslp_state_t nxt;
  logic                    accept;
  logic                    ev;

  // register image as software sees it; reserved bits stay zero
  function automatic logic [31:0] read_word(
    input logic [7:0]              a,
    input scslp_pkg::scslp_state_t st
  );
    logic [31:0] w;
    w = 32'h0;
    case (a)
      scslp_pkg::OFS_LPC: begin
        w[scslp_pkg::LPC_EVPEND_BIT] = st.evpend_sel;
        w[scslp_pkg::LPC_DEEP_BIT]   = st.deep_sel;
        w[scslp_pkg::LPC_SOE_BIT]    = st.soe_sel;
      end
      scslp_pkg::OFS_CBI: begin
        w = scslp_pkg::CBI_VALUE;
      end
      scslp_pkg::OFS_HP2: begin
        w[scslp_pkg::PRI_SVC_LSB+scslp_pkg::PRI_KEEP_OFS +: 2] = st.prio.svc;
      end
      scslp_pkg::OFS_HP3: begin
        w[scslp_pkg::PRI_TICK_LSB+scslp_pkg::PRI_KEEP_OFS +: 2] = st.prio.tick;
        w[scslp_pkg::PRI_PEND_LSB+scslp_pkg::PRI_KEEP_OFS +: 2] = st.prio.pend;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel && hready && htrans[1];

  // any wake source; disabled interrupts count only with pending-event select
  assign ev = wake_in.sev_exec || wake_in.event_in ||
              (wake_in.irq_new && (wake_in.irq_new_enabled || s.evpend_sel));

  // next-state logic for the whole block
  always_comb begin
    nxt           = s;
    nxt.wake_up   = 1'b0;
    nxt.sleep_req = 1'b0;

    // data phase of a write; only whole words reach the registers
    if (s.dp_write) begin
      unique case (s.dp_addr)
        scslp_pkg::OFS_LPC: begin
          nxt.evpend_sel = hwdata[scslp_pkg::LPC_EVPEND_BIT];
          nxt.deep_sel   = hwdata[scslp_pkg::LPC_DEEP_BIT];
          nxt.soe_sel    = hwdata[scslp_pkg::LPC_SOE_BIT];
        end
        scslp_pkg::OFS_HP2: begin
          // low six bits of the field are simply not stored
          nxt.prio.svc = hwdata[scslp_pkg::PRI_SVC_LSB+scslp_pkg::PRI_KEEP_OFS +: 2];
        end
        scslp_pkg::OFS_HP3: begin
          nxt.prio.tick = hwdata[scslp_pkg::PRI_TICK_LSB+scslp_pkg::PRI_KEEP_OFS +: 2];
          nxt.prio.pend = hwdata[scslp_pkg::PRI_PEND_LSB+scslp_pkg::PRI_KEEP_OFS +: 2];
        end
        default: begin
          // indicators and unmapped space: write dropped
          nxt.dp_addr = s.dp_addr;
        end
      endcase
    end

    // address phase; a narrow write is dropped rather than merged
    nxt.dp_write = accept && hwrite && (hsize == scslp_pkg::HSIZE_WORD);
    nxt.dp_addr  = haddr[7:0];
    // read data from the post-write image, so back-to-back write/read is coherent
    if (accept && !hwrite) begin
      nxt.hrdata = read_word(haddr[7:0], nxt);
    end

    // wait-for-event sequencing
    unique case (s.wk)
      scslp_pkg::WK_RUN: begin
        if (wake_in.wfe_exec) begin
          if (s.event_latched || ev) begin
            nxt.wake_up       = 1'b1;
            nxt.event_latched = 1'b0;
          end else begin
            nxt.wk = scslp_pkg::WK_WAIT;
          end
        end else if (ev) begin
          nxt.event_latched = 1'b1;
        end
      end
      scslp_pkg::WK_WAIT: begin
        if (ev) begin
          nxt.wake_up = 1'b1;
          nxt.wk      = scslp_pkg::WK_RUN;
        end
      end
    endcase

    // return to thread mode sleeps only when enabled
    nxt.sleep_req = handler_return_to_thread && s.soe_sel;
  end

  // all state in one register, frozen while hce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s               <= '0;
      s.evpend_sel    <= scslp_pkg::LPC_BIT_RESET;
      s.deep_sel      <= scslp_pkg::LPC_BIT_RESET;
      s.soe_sel       <= scslp_pkg::LPC_BIT_RESET;
      s.prio.svc      <= scslp_pkg::PRI_RESET;
      s.prio.pend     <= scslp_pkg::PRI_RESET;
      s.prio.tick     <= scslp_pkg::PRI_RESET;
      s.wk            <= scslp_pkg::WK_RUN;
    end else if (hce) begin
      s <= nxt;
    end
  end

  // outputs straight from flops
  assign hrdata                = s.hrdata;
  assign pwr_out.wake_up       = s.wake_up;
  assign pwr_out.sleep_request = s.sleep_req;
  assign pwr_out.deep_sleep    = s.deep_sel;
  assign pwr_out.event_latched = s.event_latched;
  assign sys_prio              = s.prio;

  scslp_arb u_arb (
    .pend      (sys_pend),
    .prio      (s.prio),
    .win_valid (sys_win_valid),
    .win_id    (sys_win_id)
  );

  scslp_align u_align (
    .exc_entry      (exc_entry),
    .exc_return     (exc_return),
    .sp_in          (sp_in),
    .psr_align_in   (psr_align_in),
    .access_valid   (access_valid),
    .access_addr    (access_addr),
    .access_size    (access_size),
    .sp_out         (sp_out),
    .psr_align_out  (psr_align_out),
    .hard_fault_req (hard_fault_req)
  );

  // checks on the block's own outputs
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_disabled_irq_block:
  assert property (hce && s.wk == scslp_pkg::WK_WAIT && wake_in.irq_new &&
                   !wake_in.irq_new_enabled && !s.evpend_sel && !wake_in.event_in &&
                   !wake_in.sev_exec |=> !pwr_out.wake_up)
    else $error("disabled interrupt woke the core");

  a_pending_any_wake:
  assert property (hce && s.wk == scslp_pkg::WK_WAIT && wake_in.irq_new && s.evpend_sel
                   |=> pwr_out.wake_up && s.wk == scslp_pkg::WK_RUN)
    else $error("interrupt with pending-event select did not wake");

  a_event_latch_next:
  assert property (hce && s.wk == scslp_pkg::WK_RUN && !wake_in.wfe_exec && ev
                   ##1 hce && wake_in.wfe_exec
                   |=> pwr_out.wake_up && s.wk == scslp_pkg::WK_RUN)
    else $error("latched event did not return next wait at once");

  a_send_event_wake:
  assert property (hce && s.wk == scslp_pkg::WK_WAIT && wake_in.sev_exec
                   |=> pwr_out.wake_up ##1 (!pwr_out.wake_up || !$past(hce)))
    else $error("send event did not give one wake pulse");

  a_deep_from_write:
  assert property (hce && s.dp_write && s.dp_addr == scslp_pkg::OFS_LPC
                   |=> pwr_out.deep_sleep == $past(hwdata[scslp_pkg::LPC_DEEP_BIT]))
    else $error("deep sleep select not taken from write");

  a_exit_sleep_gate:
  assert property (hce && handler_return_to_thread
                   |=> pwr_out.sleep_request == $past(s.soe_sel))
    else $error("sleep request does not follow sleep-on-exit");

  a_indicator_read:
  assert property (hce && accept && !hwrite && haddr[7:0] == scslp_pkg::OFS_CBI
                   |=> hrdata[scslp_pkg::CBI_STK_BIT] && hrdata[scslp_pkg::CBI_UNAL_BIT] &&
                       hrdata == scslp_pkg::CBI_VALUE)
    else $error("indicator register read wrong value");

  a_indicator_no_write:
  assert property (hce && accept && hwrite && haddr[7:0] == scslp_pkg::OFS_CBI
                   ##1 hce && accept && !hwrite && haddr[7:0] == scslp_pkg::OFS_CBI
                   |=> hrdata == scslp_pkg::CBI_VALUE)
    else $error("indicator register changed by a write");

  a_prio_low_zero:
  assert property (hce && accept && !hwrite && haddr[7:0] == scslp_pkg::OFS_HP3
                   |=> hrdata[15:0] == 16'h0 && hrdata[21:16] == 6'h0 &&
                       hrdata[29:24] == 6'h0)
    else $error("unimplemented priority bits read nonzero");

  a_svc_prio_store:
  assert property (hce && s.dp_write && s.dp_addr == scslp_pkg::OFS_HP2
                   |=> s.prio.svc == $past(hwdata[31:30]))
    else $error("supervisor call priority not stored from bits 31:30");

  a_unaligned_fault:
  assert property (access_valid && access_size == scslp_pkg::ASIZE_WORD &&
                   access_addr != 2'h0 |-> hard_fault_req)
    else $error("unaligned word access did not fault");

  a_entry_align:
  assert property (exc_entry |-> sp_out[2:0] == 3'h0 && psr_align_out == sp_in[2])
    else $error("stack not aligned or pad not recorded");

  a_arb_urgent:
  assert property (sys_pend == 3'h3 && s.prio.pend < s.prio.svc
                   |-> sys_win_valid && sys_win_id == 2'h1)
    else $error("less urgent exception won arbitration");

  c_wake_from_wait:
  cover property (s.wk == scslp_pkg::WK_WAIT ##1 pwr_out.wake_up);

  c_wfe_immediate:
  cover property (s.event_latched && wake_in.wfe_exec && hce ##1 pwr_out.wake_up);

  c_sleep_on_exit:
  cover property (pwr_out.sleep_request && pwr_out.deep_sleep);

  c_prio_readback:
  cover property (s.dp_write && s.dp_addr == scslp_pkg::OFS_HP3 ##1 accept && !hwrite);
endmodule

// ### sim/scslp_core_model.sv
// core-side model: wake requests and handler returns as one-cycle pulses
// assumes one hclk domain; counts wake and sleep pulses from the block
module scslp_core_model (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      go,
  input  wire logic [5:0]                req,
  input  wire scslp_pkg::scslp_pwr_out_t pwr_out,
  output scslp_pkg::scslp_wake_in_t      wake_in,
  output logic                           handler_return_to_thread,
  output logic [7:0]                     wake_seen,
  output logic [7:0]                     sleep_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // pulses fall back low at once so no request is seen twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_in                  <= '0;
      handler_return_to_thread <= 1'b0;
      wake_seen                <= 8'h00;
      sleep_seen               <= 8'h00;
    end else begin
      wake_in                  <= go ? scslp_pkg::scslp_wake_in_t'(req[5:1]) : '0;
      handler_return_to_thread <= go & req[0];
      wake_seen                <= wake_seen + {7'h00, pwr_out.wake_up};
      sleep_seen               <= sleep_seen + {7'h00, pwr_out.sleep_request};
    end
  end
endmodule

// ### sim/system_control_low_power_priority_test.sv
// self-checking bench: AHB-Lite register tasks, wake, sleep, priority, alignment
// assumes the block answers with zero wait states but never relies on it
module system_control_low_power_priority_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] R_IRQ = 6'h20;
  localparam logic [5:0] R_EN  = 6'h10;
  localparam logic [5:0] R_EVT = 6'h08;
  localparam logic [5:0] R_SEV = 6'h04;
  localparam logic [5:0] R_WFE = 6'h02;
  localparam logic [5:0] R_RET = 6'h01;
  logic hclk, hresetn, hce, hsel, hwrite, hready, hreadyout, hresp, go;
  logic [31:0] haddr, hwdata, hrdata, sp_in, sp_out, junk;
  logic [1:0] htrans, sys_win_id, access_addr, access_size;
  logic [2:0] hsize, sys_pend;
  logic [5:0] req;
  logic [7:0] wake_seen, sleep_seen, exp_w, exp_s;
  logic hret, exc_entry, exc_return, psr_align_in, psr_align_out;
  logic sys_win_valid, access_valid, hard_fault_req;
  scslp_pkg::scslp_wake_in_t  wake_in;
  scslp_pkg::scslp_pwr_out_t  pwr_out;
  scslp_pkg::scslp_prio_t     sys_prio;
  int bad_count, cmp_count;

  assign hready = hreadyout;

  scslp_top DUT (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake_in(wake_in),
    .handler_return_to_thread(hret), .pwr_out(pwr_out), .sys_pend(sys_pend),
    .sys_win_valid(sys_win_valid), .sys_win_id(sys_win_id), .sys_prio(sys_prio),
    .exc_entry(exc_entry), .exc_return(exc_return), .sp_in(sp_in),
    .psr_align_in(psr_align_in), .sp_out(sp_out), .psr_align_out(psr_align_out),
    .access_valid(access_valid), .access_addr(access_addr), .access_size(access_size),
    .hard_fault_req(hard_fault_req));

  scslp_core_model u_core (.hclk(hclk), .hresetn(hresetn), .go(go), .req(req),
    .pwr_out(pwr_out), .wake_in(wake_in), .handler_return_to_thread(hret),
    .wake_seen(wake_seen), .sleep_seen(sleep_seen));

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for an edge with hready high; a hang ends the run
  task automatic edge_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] sz, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= sz;
    edge_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, scslp_pkg::HSIZE_WORD, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, scslp_pkg::HSIZE_WORD, x);
    chk(x, exp);
  endtask

  // pulse from the core model, then let the wake path settle
  task automatic pulse(input logic [5:0] r);
    @(posedge hclk);
    req <= r;
    go  <= 1'b1;
    @(posedge hclk);
    go  <= 1'b0;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic unal(input logic [1:0] sz, input logic [1:0] ad, input logic e);
    @(posedge hclk);
    access_valid <= 1'b1;
    access_size  <= sz;
    access_addr  <= ad;
    @(negedge hclk);
    chk({31'h0, hard_fault_req}, {31'h0, e});
  endtask

  task automatic prio_chk(input logic [2:0] p, input logic [1:0] id);
    @(posedge hclk);
    sys_pend <= p;
    @(negedge hclk);
    chk({31'h0, sys_win_valid}, 32'h1);
    chk({30'h0, sys_win_id}, {30'h0, id});
  endtask

  initial begin
    {hsel, hwrite, go, exc_entry, exc_return, psr_align_in, access_valid} = '0;
    {haddr, hwdata, sp_in, htrans, hsize, req, sys_pend, access_addr, access_size} = '0;
    bad_count = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hce = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and unmapped read
    rd_chk(scslp_pkg::OFS_LPC, 32'h0000_0000);
    rd_chk(scslp_pkg::OFS_CBI, 32'h0000_0208);
    rd_chk(scslp_pkg::OFS_HP2, 32'h0000_0000);
    rd_chk(scslp_pkg::OFS_HP3, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    $display("test reset values done");
    // reserved and read-only bits
    wr(scslp_pkg::OFS_LPC, 32'hffff_ffff);
    rd_chk(scslp_pkg::OFS_LPC, 32'h0000_0016);
    chk({31'h0, pwr_out.deep_sleep}, 32'h1);
    wr(scslp_pkg::OFS_CBI, 32'h0000_0000);
    rd_chk(scslp_pkg::OFS_CBI, 32'h0000_0208);
    wr(scslp_pkg::OFS_HP2, 32'hffff_ffff);
    rd_chk(scslp_pkg::OFS_HP2, 32'hc000_0000);
    wr(scslp_pkg::OFS_HP3, 32'hffff_ffff);
    rd_chk(scslp_pkg::OFS_HP3, 32'hc0c0_0000);
    wr(scslp_pkg::OFS_HP2, 32'h40ff_ffff);
    rd_chk(scslp_pkg::OFS_HP2, 32'h4000_0000);
    // read-back slot goes to a scratch word so hwdata keeps a single driver
    bus(1'b1, scslp_pkg::OFS_HP2, 32'h8000_0000, 3'h1, junk);
    rd_chk(scslp_pkg::OFS_HP2, 32'h4000_0000);
    wr(scslp_pkg::OFS_LPC, 32'h0000_0000);
    @(negedge hclk);
    chk({31'h0, pwr_out.deep_sleep}, 32'h0);
    $display("test register fields done");
    // wake path with pending select 0, then 1
    exp_w = wake_seen;
    pulse(R_WFE);
    pulse(R_IRQ);
    chk({24'h0, wake_seen}, {24'h0, exp_w});
    pulse(R_IRQ | R_EN);
    exp_w++;
    chk({24'h0, wake_seen}, {24'h0, exp_w});
    pulse(R_EVT);
    chk({31'h0, pwr_out.event_latched}, 32'h1);
    pulse(R_WFE);
    exp_w++;
    chk({24'h0, wake_seen}, {24'h0, exp_w});
    chk({31'h0, pwr_out.event_latched}, 32'h0);
    pulse(R_WFE);
    pulse(R_SEV);
    exp_w++;
    chk({24'h0, wake_seen}, {24'h0, exp_w});
    wr(scslp_pkg::OFS_LPC, 32'h0000_0010);
    pulse(R_WFE);
    pulse(R_IRQ);
    exp_w++;
    chk({24'h0, wake_seen}, {24'h0, exp_w});
    // clock enable low: the event pulse is lost, nothing latches
    @(posedge hclk);
    hce <= 1'b0;
    pulse(R_EVT);
    chk({31'h0, pwr_out.event_latched}, 32'h0);
    hce <= 1'b1;
    $display("test wake done");
    // sleep on handler return
    exp_s = sleep_seen;
    wr(scslp_pkg::OFS_LPC, 32'h0000_0006);
    pulse(R_RET);
    exp_s++;
    chk({24'h0, sleep_seen}, {24'h0, exp_s});
    wr(scslp_pkg::OFS_LPC, 32'h0000_0000);
    pulse(R_RET);
    chk({24'h0, sleep_seen}, {24'h0, exp_s});
    $display("test sleep done");
    // arbitration: svc 3, pendable 1, tick 2, then all equal
    wr(scslp_pkg::OFS_HP2, 32'hc000_0000);
    wr(scslp_pkg::OFS_HP3, 32'h8040_0000);
    // priorities update at the write edge; look once they have settled
    @(negedge hclk);
    chk({26'h0, sys_prio}, 32'h0000_0036);
    prio_chk(3'h7, 2'h1);
    prio_chk(3'h5, 2'h2);
    prio_chk(3'h1, 2'h0);
    wr(scslp_pkg::OFS_HP3, 32'h0000_0000);
    wr(scslp_pkg::OFS_HP2, 32'h0000_0000);
    prio_chk(3'h6, 2'h1);
    $display("test priority done");
    // alignment on entry and return, unaligned trap
    @(posedge hclk);
    exc_entry <= 1'b1;
    sp_in     <= 32'h0000_1004;
    @(negedge hclk);
    chk(sp_out, 32'h0000_1000);
    chk({31'h0, psr_align_out}, 32'h1);
    @(posedge hclk);
    exc_entry    <= 1'b0;
    exc_return   <= 1'b1;
    psr_align_in <= 1'b1;
    sp_in        <= 32'h0000_1000;
    @(negedge hclk);
    chk(sp_out, 32'h0000_1004);
    unal(scslp_pkg::ASIZE_WORD, 2'h1, 1'b1);
    unal(scslp_pkg::ASIZE_WORD, 2'h0, 1'b0);
    unal(scslp_pkg::ASIZE_HALF, 2'h2, 1'b0);
    unal(scslp_pkg::ASIZE_HALF, 2'h3, 1'b1);
    unal(2'h0, 2'h3, 1'b0);
    $display("test alignment done");
    // second reset in mid-run clears the stored fields
    wr(scslp_pkg::OFS_HP3, 32'h4000_0000);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(scslp_pkg::OFS_HP3, 32'h0000_0000);
    $display("test second reset done");
    summarize();
  end
endmodule
